// *** flash_lock_pkg.sv ***
// Shared constants and types for the flash lock command link
package flash_lock_pkg;
	localparam int CLK_PERIOD_NS    = 5;
	localparam int LOCK_SET_TIME_NS = 50000;
	localparam int LOCK_CLR_TIME_NS = 100000;
	localparam int SEC_PROG_TIME_NS = 40000;
	localparam int LOCK_SET_CYCLES  = (LOCK_SET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_CLR_CYCLES  = (LOCK_CLR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEC_PROG_CYCLES  = (SEC_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] HALF_PERIOD_CYCLES = 4'h8;

	localparam logic [7:0] OP_STATUS       = 8'h05;
	localparam logic [7:0] OP_WRITE_LATCH  = 8'h06;
	localparam logic [7:0] OP_SEC_PROG     = 8'h42;
	localparam logic [7:0] OP_SEC_READ     = 8'h48;
	localparam logic [7:0] OP_GLOBAL_LOCK  = 8'h7E;
	localparam logic [7:0] OP_GLOBAL_FREE  = 8'h98;
	localparam logic [7:0] OP_READ_VOL     = 8'hE0;
	localparam logic [7:0] OP_WRITE_VOL    = 8'hE1;
	localparam logic [7:0] OP_READ_NONVOL  = 8'hE2;
	localparam logic [7:0] OP_SET_NONVOL   = 8'hE3;
	localparam logic [7:0] OP_CLEAR_NONVOL = 8'hE4;

	localparam logic [7:0] LOCK_ON      = 8'hFF;
	localparam logic [7:0] LOCK_OFF     = 8'h00;
	localparam logic [7:0] SEC_BLANK    = 8'hFF;
	localparam int         LOCK_IDX_LSB = 16;
	localparam int         LOCK_IDX_W   = 4;
	localparam int         NUM_LOCKS    = 16;
	localparam int         SEC_WORDS    = 12288;
	localparam logic [3:0] SEC_SEL_MIN  = 4'h1;
	localparam logic [3:0] SEC_SEL_MAX  = 4'h3;
	localparam logic [5:0] CMD_BITS     = 6'h08;
	localparam logic [5:0] ADDR3_BITS   = 6'h18;
	localparam logic [5:0] ADDR4_BITS   = 6'h20;
	localparam logic [5:0] DUMMY_BITS   = 6'h08;
	localparam logic [5:0] SYNC_RESET   = 6'h2F;
	localparam int         STAT_BUSY    = 0;
	localparam int         STAT_LATCH   = 1;

	typedef enum logic [2:0] {D_CMD, D_ADDR, D_DUMMY, D_WDATA, D_END, D_OUT, D_IGNORE} dev_state_t;
	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} host_state_t;
endpackage

// *** flash_link_if.sv ***
// Serial link between lock command host and flash device
`timescale 1ns/1ps
interface flash_link_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] host_io_o;
	logic [3:0] host_io_oe;
	logic [3:0] dev_io_o;
	logic [3:0] dev_io_oe;
	logic [3:0] io;

	// Wire level per bit, pulled high when nobody drives
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io[i] = dev_io_oe[i] ? dev_io_o[i] : (host_io_oe[i] ? host_io_o[i] : 1'b1);
		end
	end

	modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
	modport dev  (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
endinterface

// *** flash_lock_device.sv ***
// Flash device end: security register and sector lock command logic
// Behaviour
// - Security address: high byte zero, select, page, byte
// - Read security: opcode, address, one dummy byte
// - Security read data out on falling edges, incrementing
// - Read wraps low twelve address bits to zero, program low eight
// - Security address 24 bits, 32 in four-byte mode
// - Global lock sets, global unlock clears volatile lock bits
// - Host sets write latch before lock set
// - Lock set takes opcode plus 32-bit address
// - Lock set needs select high right after address
// - Lock set timed cycle, busy, then byte FF
// - Nonvolatile lock resets 00, FF protects sector
// - Clear all: lone opcode, latch, exact length
// - Clear all timed, clears every nonvolatile lock, drops latch
// - Nonvolatile locks set singly, cleared only together
// - Volatile write: latch, opcode, address, one byte
// - Volatile write ignored unless data 00 or FF
// - Volatile write immediate at select high, drops latch
// - Volatile lock FF protects, 00 unprotects unless nonvolatile lock is FF
// - Lock read outputs byte after address falling edge
// - Lock read ignored while a cycle runs
// - Security program: latch, address, data, timed cycle
// - Security lock bit blocks security programming
`timescale 1ns/1ps
module flash_lock_device #(
	parameter int LOCK_SET_CYCLES = flash_lock_pkg::LOCK_SET_CYCLES,
	parameter int LOCK_CLR_CYCLES = flash_lock_pkg::LOCK_CLR_CYCLES,
	parameter int SEC_PROG_CYCLES = flash_lock_pkg::SEC_PROG_CYCLES
) (
	input  wire logic                                 CLOCK_I,
	input  wire logic                                 RESET_N_I,
	input  wire logic                                 QUAD_COMMAND_MODE_I,
	input  wire logic                                 FOUR_BYTE_MODE_I,
	input  wire logic                                 SEC_LOCK_I,
	flash_link_if.dev                                 LINK,
	output logic                                      WRITE_ENABLE_LATCH_O,
	output logic                                      WRITE_IN_PROGRESS_O,
	output logic [flash_lock_pkg::NUM_LOCKS-1:0]      PROTECT_O
);
	logic [5:0]                 s1_q;
	logic [5:0]                 s2_q;
	logic                       sclk_prev_q;
	logic                       cs_prev_q;
	logic                       cs_low;
	logic                       rise;
	logic                       fall;
	logic                       cs_rise;
	logic [5:0]                 step;
	logic [5:0]                 phase_len;
	logic                       done;
	logic [7:0]                 sh8;
	flash_lock_pkg::dev_state_t state_q;
	logic [5:0]                 cnt_q;
	logic [7:0]                 sh_q;
	logic [7:0]                 op_q;
	logic [7:0]                 data_q;
	logic                       prog_any_q;
	logic [31:0]                addr_q;
	logic                       wbyte;
	logic                       prog_ok;
	logic [3:0]                 idx_q;
	logic [7:0]                 cur_q;
	logic [7:0]                 rd_byte;
	logic [7:0]                 out_b;
	logic [7:0]                 out_s;
	logic                       out_adv;
	logic [3:0]                 io_q;
	logic [3:0]                 oe_q;
	logic                       wel_q;
	logic [31:0]                busy_q;
	logic [7:0]                 busy_op_q;
	logic [3:0]                 target_q;
	logic [7:0]                 nonvol_q [flash_lock_pkg::NUM_LOCKS];
	logic [7:0]                 vol_q    [flash_lock_pkg::NUM_LOCKS];
	logic [7:0]                 sec_mem  [flash_lock_pkg::SEC_WORDS];

	function automatic logic sec_ok(input logic [31:0] a);
		return (a[31:16] == 16'h0000) && (a[15:12] >= flash_lock_pkg::SEC_SEL_MIN) &&
			(a[15:12] <= flash_lock_pkg::SEC_SEL_MAX);
	endfunction

	function automatic logic [13:0] sec_index(input logic [31:0] a);
		return {2'(a[13:12] - 2'h1), a[11:0]};
	endfunction

	function automatic logic [3:0] lock_index(input logic [31:0] a);
		return a[flash_lock_pkg::LOCK_IDX_LSB +: flash_lock_pkg::LOCK_IDX_W];
	endfunction

	// Two-stage synchronisers for select, clock and data lines
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			s1_q        <= flash_lock_pkg::SYNC_RESET;
			s2_q        <= flash_lock_pkg::SYNC_RESET;
			sclk_prev_q <= 1'b0;
			cs_prev_q   <= 1'b1;
		end else begin
			s1_q        <= {LINK.cs_n, LINK.sclk, LINK.io};
			s2_q        <= s1_q;
			sclk_prev_q <= s2_q[4];
			cs_prev_q   <= s2_q[5];
		end
	end

	assign cs_low  = !s2_q[5];
	assign rise    = s2_q[4] && !sclk_prev_q && cs_low;
	assign fall    = !s2_q[4] && sclk_prev_q && cs_low;
	assign cs_rise = s2_q[5] && !cs_prev_q;
	assign step    = QUAD_COMMAND_MODE_I ? 6'h04 : 6'h01;
	assign sh8     = QUAD_COMMAND_MODE_I ? {sh_q[3:0], s2_q[3:0]} : {sh_q[6:0], s2_q[0]};

	always_comb begin
		case (state_q)
			flash_lock_pkg::D_CMD: phase_len = flash_lock_pkg::CMD_BITS;
			flash_lock_pkg::D_ADDR: begin
				if (op_q == flash_lock_pkg::OP_SEC_READ || op_q == flash_lock_pkg::OP_SEC_PROG) begin
					phase_len = FOUR_BYTE_MODE_I ? flash_lock_pkg::ADDR4_BITS : flash_lock_pkg::ADDR3_BITS;
				end else begin
					phase_len = flash_lock_pkg::ADDR4_BITS;
				end
			end
			default: phase_len = flash_lock_pkg::DUMMY_BITS;
		endcase
	end

	assign done  = 6'(cnt_q + step) == phase_len;
	assign wbyte = rise && state_q == flash_lock_pkg::D_WDATA && done;
	assign prog_ok = wbyte && op_q == flash_lock_pkg::OP_SEC_PROG && wel_q && !SEC_LOCK_I && sec_ok(addr_q);

	// Command sequencer
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I || !cs_low) begin
			state_q    <= flash_lock_pkg::D_CMD;
			cnt_q      <= 6'h00;
			sh_q       <= 8'h00;
			op_q       <= 8'h00;
			data_q     <= 8'h00;
			prog_any_q <= 1'b0;
		end else if (rise) begin
			sh_q  <= sh8;
			cnt_q <= done ? 6'h00 : 6'(cnt_q + step);
			if (prog_ok) begin
				prog_any_q <= 1'b1;
			end
			case (state_q)
				flash_lock_pkg::D_CMD: begin
					if (done) begin
						op_q <= sh8;
						if (busy_q != 32'h0000_0000 && sh8 != flash_lock_pkg::OP_STATUS) begin
							state_q <= flash_lock_pkg::D_IGNORE;
						end else begin
							case (sh8)
								flash_lock_pkg::OP_WRITE_LATCH, flash_lock_pkg::OP_GLOBAL_LOCK,
								flash_lock_pkg::OP_GLOBAL_FREE, flash_lock_pkg::OP_CLEAR_NONVOL:
									state_q <= flash_lock_pkg::D_END;
								flash_lock_pkg::OP_SET_NONVOL, flash_lock_pkg::OP_WRITE_VOL,
								flash_lock_pkg::OP_READ_NONVOL, flash_lock_pkg::OP_READ_VOL,
								flash_lock_pkg::OP_SEC_READ, flash_lock_pkg::OP_SEC_PROG:
									state_q <= flash_lock_pkg::D_ADDR;
								flash_lock_pkg::OP_STATUS: state_q <= flash_lock_pkg::D_OUT;
								default: state_q <= flash_lock_pkg::D_IGNORE;
							endcase
						end
					end
				end
				flash_lock_pkg::D_ADDR: begin
					if (done) begin
						case (op_q)
							flash_lock_pkg::OP_SET_NONVOL: state_q <= flash_lock_pkg::D_END;
							flash_lock_pkg::OP_WRITE_VOL, flash_lock_pkg::OP_SEC_PROG: state_q <= flash_lock_pkg::D_WDATA;
							flash_lock_pkg::OP_SEC_READ: state_q <= flash_lock_pkg::D_DUMMY;
							default: state_q <= flash_lock_pkg::D_OUT;
						endcase
					end
				end
				flash_lock_pkg::D_DUMMY: begin
					if (done) begin
						state_q <= flash_lock_pkg::D_OUT;
					end
				end
				flash_lock_pkg::D_WDATA: begin
					if (done) begin
						data_q <= sh8;
						if (op_q == flash_lock_pkg::OP_WRITE_VOL) begin
							state_q <= flash_lock_pkg::D_END;
						end
					end
				end
				flash_lock_pkg::D_END: state_q <= flash_lock_pkg::D_IGNORE;
				default: state_q <= state_q;
			endcase
		end
	end

	// Address register: shift in, then advance during data
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I || !cs_low) begin
			addr_q <= 32'h0000_0000;
		end else if (rise && state_q == flash_lock_pkg::D_ADDR) begin
			addr_q <= QUAD_COMMAND_MODE_I ? {addr_q[27:0], s2_q[3:0]} : {addr_q[30:0], s2_q[0]};
		end else if (out_adv && op_q == flash_lock_pkg::OP_SEC_READ) begin
			addr_q <= {addr_q[31:12], 12'(addr_q[11:0] + 12'h001)};
		end else if (wbyte && op_q == flash_lock_pkg::OP_SEC_PROG) begin
			addr_q <= {addr_q[31:8], 8'(addr_q[7:0] + 8'h01)};
		end
	end

	// Security register storage
	always_ff @(posedge CLOCK_I) begin
		if (prog_ok) begin
			sec_mem[sec_index(addr_q)] <= sh8;
		end
	end

	always_comb begin
		case (op_q)
			flash_lock_pkg::OP_STATUS: begin
				rd_byte = 8'h00;
				rd_byte[flash_lock_pkg::STAT_BUSY]  = busy_q != 32'h0000_0000;
				rd_byte[flash_lock_pkg::STAT_LATCH] = wel_q;
			end
			flash_lock_pkg::OP_READ_NONVOL: rd_byte = nonvol_q[lock_index(addr_q)];
			flash_lock_pkg::OP_READ_VOL:    rd_byte = vol_q[lock_index(addr_q)];
			flash_lock_pkg::OP_SEC_READ:    rd_byte = sec_ok(addr_q) ? sec_mem[sec_index(addr_q)] : flash_lock_pkg::SEC_BLANK;
			default:                        rd_byte = flash_lock_pkg::SEC_BLANK;
		endcase
	end

	assign out_b   = (idx_q == 4'h0) ? rd_byte : cur_q;
	assign out_s   = 8'(out_b << idx_q);
	assign out_adv = fall && state_q == flash_lock_pkg::D_OUT && 4'(idx_q + step[3:0]) == 4'h8;

	// Output shifter, changes on falling serial clock, clears whenever the sequencer leaves the output state
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I || state_q != flash_lock_pkg::D_OUT) begin
			idx_q <= 4'h0;
			cur_q <= 8'h00;
			io_q  <= 4'h0;
			oe_q  <= 4'h0;
		end else if (fall) begin
			cur_q <= out_b;
			idx_q <= out_adv ? 4'h0 : 4'(idx_q + step[3:0]);
			io_q  <= QUAD_COMMAND_MODE_I ? out_s[7:4] : {2'b00, out_s[7], 1'b0};
			oe_q  <= QUAD_COMMAND_MODE_I ? 4'hF : 4'h2;
		end
	end

	assign LINK.dev_io_o  = io_q;
	assign LINK.dev_io_oe = oe_q;

	// Command execution at select high and self-timed cycles
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			wel_q     <= 1'b0;
			busy_q    <= 32'h0000_0000;
			busy_op_q <= 8'h00;
			target_q  <= 4'h0;
			for (int i = 0; i < flash_lock_pkg::NUM_LOCKS; i++) begin
				nonvol_q[i] <= flash_lock_pkg::LOCK_OFF;
				vol_q[i]    <= flash_lock_pkg::LOCK_OFF;
			end
		end else if (busy_q != 32'h0000_0000) begin
			busy_q <= busy_q - 32'h0000_0001;
			if (busy_q == 32'h0000_0001) begin
				wel_q <= 1'b0;
				if (busy_op_q == flash_lock_pkg::OP_SET_NONVOL) begin
					nonvol_q[target_q] <= flash_lock_pkg::LOCK_ON;
				end else if (busy_op_q == flash_lock_pkg::OP_CLEAR_NONVOL) begin
					for (int i = 0; i < flash_lock_pkg::NUM_LOCKS; i++) begin
						nonvol_q[i] <= flash_lock_pkg::LOCK_OFF;
					end
				end
			end
		end else if (cs_rise && state_q == flash_lock_pkg::D_END) begin
			case (op_q)
				flash_lock_pkg::OP_WRITE_LATCH: wel_q <= 1'b1;
				flash_lock_pkg::OP_GLOBAL_LOCK: begin
					for (int i = 0; i < flash_lock_pkg::NUM_LOCKS; i++) begin
						vol_q[i] <= flash_lock_pkg::LOCK_ON;
					end
				end
				flash_lock_pkg::OP_GLOBAL_FREE: begin
					for (int i = 0; i < flash_lock_pkg::NUM_LOCKS; i++) begin
						vol_q[i] <= flash_lock_pkg::LOCK_OFF;
					end
				end
				flash_lock_pkg::OP_SET_NONVOL: begin
					if (wel_q) begin
						busy_q    <= 32'(LOCK_SET_CYCLES);
						busy_op_q <= op_q;
						target_q  <= lock_index(addr_q);
					end
				end
				flash_lock_pkg::OP_CLEAR_NONVOL: begin
					if (wel_q) begin
						busy_q    <= 32'(LOCK_CLR_CYCLES);
						busy_op_q <= op_q;
					end
				end
				flash_lock_pkg::OP_WRITE_VOL: begin
					if (wel_q && (data_q == flash_lock_pkg::LOCK_ON || data_q == flash_lock_pkg::LOCK_OFF)) begin
						vol_q[lock_index(addr_q)] <= data_q;
						wel_q                     <= 1'b0;
					end
				end
				default: wel_q <= wel_q;
			endcase
		end else if (cs_rise && state_q == flash_lock_pkg::D_WDATA && op_q == flash_lock_pkg::OP_SEC_PROG &&
				cnt_q == 6'h00 && prog_any_q) begin
			busy_q    <= 32'(SEC_PROG_CYCLES);
			busy_op_q <= op_q;
		end
	end

	always_comb begin
		for (int i = 0; i < flash_lock_pkg::NUM_LOCKS; i++) begin
			PROTECT_O[i] = nonvol_q[i] == flash_lock_pkg::LOCK_ON || vol_q[i] == flash_lock_pkg::LOCK_ON;
		end
	end

	assign WRITE_ENABLE_LATCH_O = wel_q;
	assign WRITE_IN_PROGRESS_O  = busy_q != 32'h0000_0000;
endmodule

// *** flash_lock_host.sv ***
// Host end: frames one command, address, data write and read per request
`timescale 1ns/1ps
module flash_lock_host (
	input  wire logic  CLOCK_I,
	input  wire logic  RESET_N_I,
	input  wire logic  QUAD_COMMAND_MODE_I,
	input  wire logic  REQ_VALID_I,
	output logic       REQ_READY_O,
	input  wire logic  [7:0] OPCODE_I,
	input  wire logic  [31:0] ADDR_I,
	input  wire logic  [2:0] ADDR_BYTES_I,
	input  wire logic  DUMMY_I,
	input  wire logic  [7:0] WR_BYTES_I,
	input  wire logic  [7:0] WR_DATA_I,
	output logic       WR_TAKE_O,
	input  wire logic  [7:0] RD_BYTES_I,
	output logic       [7:0] RD_DATA_O,
	output logic       RD_VALID_O,
	output logic       DONE_O,
	flash_link_if.host LINK
);
	flash_lock_pkg::host_state_t state_q;
	logic [3:0]  tim_q;
	logic        tick;
	logic        quad_q;
	logic [11:0] hdr_q;
	logic [11:0] wr_end_q;
	logic [11:0] total_q;
	logic [11:0] pos_q;
	logic [47:0] sh_q;
	logic [47:0] cur;
	logic [7:0]  rx_q;
	logic [7:0]  rx_next;
	logic [11:0] step;
	logic        in_wr;
	logic        period;
	logic [3:0]  io_s1_q;
	logic [3:0]  io_s2_q;
	logic        cs_n_q;
	logic        sclk_q;
	logic [3:0]  io_q;
	logic [3:0]  oe_q;

	// Data lines pass two flip-flops before use
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			io_s1_q <= 4'hF;
			io_s2_q <= 4'hF;
		end else begin
			io_s1_q <= LINK.io;
			io_s2_q <= io_s1_q;
		end
	end

	assign tick    = tim_q == 4'(flash_lock_pkg::HALF_PERIOD_CYCLES - 4'h1);
	assign step    = quad_q ? 12'h004 : 12'h001;
	assign in_wr   = pos_q >= hdr_q && pos_q < wr_end_q;
	assign cur     = (in_wr && 3'(pos_q - hdr_q) == 3'h0) ? {WR_DATA_I, 40'h00_0000_0000} : sh_q;
	assign period  = tick && (state_q == flash_lock_pkg::H_SETUP || (state_q == flash_lock_pkg::H_HIGH && pos_q < total_q));
	assign rx_next = quad_q ? {rx_q[3:0], io_s2_q} : {rx_q[6:0], io_s2_q[1]};
	assign REQ_READY_O = state_q == flash_lock_pkg::H_IDLE;

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			state_q    <= flash_lock_pkg::H_IDLE;
			tim_q      <= 4'h0;
			quad_q     <= 1'b0;
			hdr_q      <= 12'h000;
			wr_end_q   <= 12'h000;
			total_q    <= 12'h000;
			pos_q      <= 12'h000;
			sh_q       <= 48'h0000_0000_0000;
			rx_q       <= 8'h00;
			cs_n_q     <= 1'b1;
			sclk_q     <= 1'b0;
			io_q       <= 4'h0;
			oe_q       <= 4'h0;
			WR_TAKE_O  <= 1'b0;
			RD_DATA_O  <= 8'h00;
			RD_VALID_O <= 1'b0;
			DONE_O     <= 1'b0;
		end else begin
			WR_TAKE_O  <= 1'b0;
			RD_VALID_O <= 1'b0;
			DONE_O     <= 1'b0;
			tim_q      <= (tick || state_q == flash_lock_pkg::H_IDLE) ? 4'h0 : 4'(tim_q + 4'h1);
			if (period) begin
				if (pos_q < wr_end_q) begin
					io_q      <= quad_q ? cur[47:44] : {3'b000, cur[47]};
					oe_q      <= quad_q ? 4'hF : 4'h1;
					sh_q      <= quad_q ? {cur[43:0], 4'h0} : {cur[46:0], 1'b0};
					WR_TAKE_O <= in_wr && 3'(pos_q - hdr_q) == 3'h0;
				end else begin
					oe_q <= 4'h0;
				end
			end
			case (state_q)
				flash_lock_pkg::H_IDLE: begin
					if (REQ_VALID_I) begin
						quad_q   <= QUAD_COMMAND_MODE_I;
						hdr_q    <= 12'(12'h008 + {ADDR_BYTES_I, 3'h0} + (DUMMY_I ? 12'h008 : 12'h000));
						wr_end_q <= 12'(12'h008 + {ADDR_BYTES_I, 3'h0} + (DUMMY_I ? 12'h008 : 12'h000) + {WR_BYTES_I, 3'h0});
						total_q  <= 12'(12'h008 + {ADDR_BYTES_I, 3'h0} + (DUMMY_I ? 12'h008 : 12'h000) +
							{WR_BYTES_I, 3'h0} + {RD_BYTES_I, 3'h0});
						pos_q    <= 12'h000;
						case (ADDR_BYTES_I)
							3'h4:    sh_q <= {OPCODE_I, ADDR_I, 8'h00};
							3'h3:    sh_q <= {OPCODE_I, ADDR_I[23:0], 16'h0000};
							default: sh_q <= {OPCODE_I, 40'h00_0000_0000};
						endcase
						cs_n_q  <= 1'b0;
						state_q <= flash_lock_pkg::H_SETUP;
					end
				end
				flash_lock_pkg::H_SETUP: begin
					if (tick) begin
						state_q <= flash_lock_pkg::H_LOW;
					end
				end
				flash_lock_pkg::H_LOW: begin
					if (tick) begin
						sclk_q  <= 1'b1;
						pos_q   <= 12'(pos_q + step);
						state_q <= flash_lock_pkg::H_HIGH;
						if (pos_q >= wr_end_q) begin
							rx_q <= rx_next;
							if (3'(pos_q + step - wr_end_q) == 3'h0) begin
								RD_DATA_O  <= rx_next;
								RD_VALID_O <= 1'b1;
							end
						end
					end
				end
				flash_lock_pkg::H_HIGH: begin
					if (tick) begin
						sclk_q  <= 1'b0;
						state_q <= (pos_q >= total_q) ? flash_lock_pkg::H_HOLD : flash_lock_pkg::H_LOW;
					end
				end
				flash_lock_pkg::H_HOLD: begin
					if (tick) begin
						cs_n_q  <= 1'b1;
						oe_q    <= 4'h0;
						state_q <= flash_lock_pkg::H_GAP;
					end
				end
				flash_lock_pkg::H_GAP: begin
					if (tick) begin
						DONE_O  <= 1'b1;
						state_q <= flash_lock_pkg::H_IDLE;
					end
				end
				default: state_q <= flash_lock_pkg::H_IDLE;
			endcase
		end
	end

	assign LINK.cs_n       = cs_n_q;
	assign LINK.sclk       = sclk_q;
	assign LINK.host_io_o  = io_q;
	assign LINK.host_io_oe = oe_q;
endmodule

// *** flash_lock_props.sv ***
// Checker for the link signals and device status flags
`timescale 1ns/1ps
module flash_lock_props (
	input  wire logic       CLOCK_I,
	input  wire logic       RESET_N_I,
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic [3:0] host_io_oe,
	input  wire logic [3:0] dev_io_oe,
	input  wire logic       WRITE_ENABLE_LATCH_O,
	input  wire logic       WRITE_IN_PROGRESS_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);

	sclk_idle_a: assert property (cs_n |-> !sclk)
		else $error("serial clock moved while deselected");
	sclk_half_a: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
		else $error("serial clock high phase not eight cycles");
	cs_setup_a: assert property ($fell(cs_n) |-> !sclk[*8])
		else $error("serial clock rose too soon after select");
	no_clash_a: assert property ((host_io_oe & dev_io_oe) == 4'h0)
		else $error("both ends drive the data lines");
	dev_quiet_a: assert property (cs_n[*6] |-> dev_io_oe == 4'h0)
		else $error("device drives while deselected");
	busy_start_a: assert property ($rose(WRITE_IN_PROGRESS_O) |-> cs_n)
		else $error("busy began inside a frame");
	busy_hold_a: assert property ($rose(WRITE_IN_PROGRESS_O) |-> WRITE_IN_PROGRESS_O[*8])
		else $error("timed cycle too short");
	busy_bound_a: assert property ($rose(WRITE_IN_PROGRESS_O) |-> ##[1:1000] !WRITE_IN_PROGRESS_O)
		else $error("timed cycle never ended");
	latch_drop_a: assert property ($fell(WRITE_IN_PROGRESS_O) |-> ##[0:1] !WRITE_ENABLE_LATCH_O)
		else $error("latch kept after timed cycle");

	cover property ($rose(WRITE_IN_PROGRESS_O));
	cover property ($fell(WRITE_ENABLE_LATCH_O) && !WRITE_IN_PROGRESS_O);
	cover property (dev_io_oe != 4'h0);
endmodule

// *** flash_security_and_lock_commands_bench.sv ***
// Bench joining lock command host and device over the link
`timescale 1ns/1ps
module flash_security_and_lock_commands_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_ready;
	logic [7:0]  opcode = 8'h00;
	logic [31:0] addr = 32'h0000_0000;
	logic [2:0]  addr_bytes = 3'h0;
	logic        dummy = 1'b0;
	logic        quad = 1'b0;
	logic        four_byte = 1'b0;
	logic        sec_lock = 1'b0;
	logic [7:0]  wr_bytes = 8'h00;
	logic [7:0]  wr_data = 8'h00;
	logic [7:0]  rd_bytes = 8'h00;
	logic [7:0]  rd_data;
	logic        rd_valid;
	logic        done;
	logic        write_enable_latch;
	logic        write_in_progress_flag;
	logic [15:0] protect;
	logic [7:0]  rd;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	flash_link_if link();
	always #2.5 clk = ~clk;

	flash_lock_host u_flash_lock_host (.CLOCK_I(clk), .RESET_N_I(rst_n), .QUAD_COMMAND_MODE_I(quad),
		.REQ_VALID_I(req_valid), .REQ_READY_O(req_ready), .OPCODE_I(opcode), .ADDR_I(addr),
		.ADDR_BYTES_I(addr_bytes), .DUMMY_I(dummy), .WR_BYTES_I(wr_bytes), .WR_DATA_I(wr_data), .WR_TAKE_O(),
		.RD_BYTES_I(rd_bytes), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .DONE_O(done), .LINK(link));
	flash_lock_device #(.LOCK_SET_CYCLES(20), .LOCK_CLR_CYCLES(900), .SEC_PROG_CYCLES(20)) u_flash_lock_device (
		.CLOCK_I(clk), .RESET_N_I(rst_n), .QUAD_COMMAND_MODE_I(quad), .FOUR_BYTE_MODE_I(four_byte),
		.SEC_LOCK_I(sec_lock),
		.LINK(link), .WRITE_ENABLE_LATCH_O(write_enable_latch), .WRITE_IN_PROGRESS_O(write_in_progress_flag), .PROTECT_O(protect));
	flash_lock_props u_flash_lock_props (.CLOCK_I(clk), .RESET_N_I(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
		.host_io_oe(link.host_io_oe), .dev_io_oe(link.dev_io_oe), .WRITE_ENABLE_LATCH_O(write_enable_latch),
		.WRITE_IN_PROGRESS_O(write_in_progress_flag));

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One framed command; last read byte lands in rd
	task automatic cmd(input logic [7:0] op, input logic [2:0] ab = 3'h0, input logic [31:0] a = 32'h0000_0000,
		input int nr = 0, input int nw = 0, input logic [7:0] wd = 8'h00);
		int n;
		opcode = op;
		addr_bytes = ab;
		addr = a;
		rd_bytes = 8'(nr);
		wr_bytes = 8'(nw);
		wr_data = wd;
		dummy = op == flash_lock_pkg::OP_SEC_READ;
		rd = 8'hxx;
		req_valid = 1'b1;
		while (req_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (rd_valid === 1'b1) rd = rd_data;
		end while (done !== 1'b1 && n < 3000);
		chk("frame end", 16'(done), 16'h0001);
	endtask

	task automatic wait_idle();
		for (int n = 0; n < 2000 && write_in_progress_flag !== 1'b0; n++) begin
			@(posedge clk);
			#1;
		end
		chk("busy end", 16'(write_in_progress_flag), 16'h0000);
	endtask

	task automatic t_nonvol();
		chk("reset protect", protect, 16'h0000);
		cmd(flash_lock_pkg::OP_SET_NONVOL, 3'h4, 32'h0005_0000);
		wait_idle();
		chk("set without latch", protect, 16'h0000);
		cmd(flash_lock_pkg::OP_WRITE_LATCH);
		cmd(flash_lock_pkg::OP_SET_NONVOL, 3'h4, 32'h0005_0000);
		chk("set busy", 16'(write_in_progress_flag), 16'h0001);
		wait_idle();
		chk("set protect", protect, 16'h0020);
		chk("set latch", 16'(write_enable_latch), 16'h0000);
		cmd(flash_lock_pkg::OP_READ_NONVOL, 3'h4, 32'h0005_0000, 1);
		chk("read set lock", 16'(rd), 16'h00FF);
		cmd(flash_lock_pkg::OP_READ_NONVOL, 3'h4, 32'h0006_0000, 1);
		chk("read other lock", 16'(rd), 16'h0000);
		$display("nonvolatile set test done");
	endtask

	task automatic t_vol();
		cmd(flash_lock_pkg::OP_WRITE_LATCH);
		cmd(flash_lock_pkg::OP_WRITE_VOL, 3'h4, 32'h0002_0000, 0, 1, 8'h5A);
		chk("bad data protect", protect, 16'h0020);
		chk("bad data latch", 16'(write_enable_latch), 16'h0001);
		cmd(flash_lock_pkg::OP_WRITE_VOL, 3'h4, 32'h0002_0000, 0, 1, 8'hFF);
		chk("vol protect", protect, 16'h0024);
		chk("vol latch", 16'(write_enable_latch | write_in_progress_flag), 16'h0000);
		cmd(flash_lock_pkg::OP_READ_VOL, 3'h4, 32'h0002_0000, 1);
		chk("read vol", 16'(rd), 16'h00FF);
		cmd(flash_lock_pkg::OP_GLOBAL_LOCK);
		chk("global lock", protect, 16'hFFFF);
		cmd(flash_lock_pkg::OP_GLOBAL_FREE);
		chk("global unlock", protect, 16'h0020);
		$display("volatile and global test done");
	endtask

	task automatic t_clear();
		cmd(flash_lock_pkg::OP_WRITE_LATCH);
		cmd(flash_lock_pkg::OP_CLEAR_NONVOL, 3'h0, 32'h0000_0000, 0, 1, 8'h00);
		chk("long clear busy", 16'(write_in_progress_flag), 16'h0000);
		chk("long clear protect", protect, 16'h0020);
		cmd(flash_lock_pkg::OP_CLEAR_NONVOL);
		chk("clear busy", 16'(write_in_progress_flag), 16'h0001);
		cmd(flash_lock_pkg::OP_STATUS, 3'h0, 32'h0000_0000, 1);
		chk("status while busy", 16'(rd), 16'h0003);
		cmd(flash_lock_pkg::OP_READ_VOL, 3'h4, 32'h0000_0000, 1);
		chk("read while busy", 16'(rd), 16'h00FF);
		wait_idle();
		chk("clear protect", protect, 16'h0000);
		chk("clear latch", 16'(write_enable_latch), 16'h0000);
		$display("clear all test done");
	endtask

	task automatic t_sec();
		cmd(flash_lock_pkg::OP_WRITE_LATCH);
		cmd(flash_lock_pkg::OP_SEC_PROG, 3'h3, 32'h0000_1FFF, 0, 1, 8'h3C);
		chk("prog busy", 16'(write_in_progress_flag), 16'h0001);
		wait_idle();
		cmd(flash_lock_pkg::OP_WRITE_LATCH);
		cmd(flash_lock_pkg::OP_SEC_PROG, 3'h3, 32'h0000_1000, 0, 1, 8'hA5);
		wait_idle();
		sec_lock = 1'b1;
		cmd(flash_lock_pkg::OP_WRITE_LATCH);
		cmd(flash_lock_pkg::OP_SEC_PROG, 3'h3, 32'h0000_1000, 0, 1, 8'h11);
		chk("locked prog busy", 16'(write_in_progress_flag), 16'h0000);
		four_byte = 1'b1;
		cmd(flash_lock_pkg::OP_SEC_READ, 3'h4, 32'h0000_1FFF, 1);
		chk("sec read", 16'(rd), 16'h003C);
		four_byte = 1'b0;
		quad = 1'b1;
		cmd(flash_lock_pkg::OP_SEC_READ, 3'h3, 32'h0000_1FFF, 2);
		chk("sec wrap quad", 16'(rd), 16'h00A5);
		quad = 1'b0;
		$display("security register test done");
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			$display("timeout after %0d cycles", cycles);
			stop_test();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		t_nonvol();
		t_vol();
		t_clear();
		t_sec();
		stop_test();
	end
endmodule
